// ===== hdl/lit_pkg.sv
// Package for the light integration timing block.
// Assumes a single 125 MHz system clock and an APB register slave.
package lit_pkg;
    // Register byte addresses
    localparam logic [7:0] LIT_ADDR_CMD    = 8'h00;
    localparam logic [7:0] LIT_ADDR_CTRL   = 8'h04;
    localparam logic [7:0] LIT_ADDR_SYNC   = 8'h08;
    localparam logic [7:0] LIT_ADDR_STATUS = 8'h0C;
    localparam logic [7:0] LIT_ADDR_COUNT  = 8'h10;
    // Command register fields
    localparam int LIT_CMD_TMODE_BIT = 5;
    localparam int LIT_CMD_DSEL_LSB  = 2;
    localparam int LIT_CMD_WID_LSB   = 0;
    // Control register fields
    localparam int LIT_CTRL_GAIN_LSB = 2;
    // Sync register field
    localparam int LIT_SYNC_BIT = 0;
    // Reset values
    localparam logic [7:0] LIT_CMD_RST  = 8'h00;
    localparam logic [7:0] LIT_CTRL_RST = 8'h00;
    // Width encodings
    localparam logic [1:0] LIT_WID_16B = 2'h0;
    localparam logic [1:0] LIT_WID_12B = 2'h1;
    localparam logic [1:0] LIT_WID_8B  = 2'h2;
    localparam logic [1:0] LIT_WID_4B  = 2'h3;
    // Diode select encodings
    localparam logic [1:0] LIT_DSEL_D1   = 2'h0;
    localparam logic [1:0] LIT_DSEL_D2   = 2'h1;
    localparam logic [1:0] LIT_DSEL_DIFF = 2'h2;
    localparam logic [1:0] LIT_DSEL_NOP  = 2'h3;
    // Cycle count limit of the counter
    localparam logic [16:0] LIT_CNT_MAX = 17'h10000;
    // Sequencer states
    typedef enum logic [1:0]
    {
        LIT_ST_IDLE  = 2'b00,
        LIT_ST_RUN1  = 2'b01,
        LIT_ST_RUN2  = 2'b10
    } lit_state_t;
endpackage

// ===== hdl/lit_edge.sv
// Two-flop synchroniser with rising-edge detector for the oscillator pin.
// Assumes the sampled signal is slower than half the system clock.
`timescale 1ns/1ps
`default_nettype none
module lit_edge
(
    // System
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    // Pin
    input  wire logic pin_in,
    // Pulse
    output logic      rise_out
);
    logic sync_a;
    logic sync_b;
    logic sync_c;

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sync_a   <= 1'b0;
            sync_b   <= 1'b0;
            sync_c   <= 1'b0;
            rise_out <= 1'b0;
        end
        else
        begin
            sync_a   <= pin_in;
            sync_b   <= sync_a;
            sync_c   <= sync_b;
            rise_out <= sync_b & ~sync_c;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/lit_timing.sv
// Integration timing controller for an integrating light converter.
// Assumes the oscillator arrives on a pin, slower than clk_sys_in / 4,
// and that software reaches the registers over APB.
// Summary of operation
// - Bit 5 of the command register picks internal count or host sync.
// - Internal timing runs exactly 2^n oscillator cycles, n from bits 1:0.
// - Lower two gain ranges halve the oscillator rate, upper two use full.
// - The oscillator behaves the same in internal and external modes.
// - Internal mode full-scale result equals 2^n counts.
// - Single-diode external mode: each sync ends one and starts the next.
// - Difference mode steps diode 1, diode 2, then back to diode 1.
// - External mode counts oscillator cycles, at most 65536.
// - The last external period's cycle count is readable.
// - Width 00/01/10/11 gives 65536/4096/256/16 cycles.
// - Timing bit 0 is internal, 1 is external.
// - Gain bits 3:2 of the control register select ranges 1 to 4.
// - Diode bits 3:2 select diode 1, diode 2, difference or nothing.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lit_timing
    import lit_pkg::*;
(
    // System
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Oscillator pin set by the scaling_resistor_pin
    input  wire logic        osc_in,
    // Converter control
    output logic             integrate_out,
    output logic             diode2_sel_out,
    output logic             period_end_out,
    output logic             osc_tick_out
);
    // Registers
    logic [7:0]  cmd;
    logic [7:0]  ctrl;
    logic [16:0] cnt;
    logic [16:0] last_cnt;
    logic        last_diode2;
    lit_state_t  state;
    logic        half_ph;
    logic [31:0] next_prdata;

    // Oscillator edges
    logic osc_rise;
    lit_edge u_osc
    (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .pin_in     (osc_in),
        .rise_out   (osc_rise)
    );

    function automatic logic [16:0] lit_cycles(input logic [1:0] w);
        logic [16:0] r;
        r = 17'h10000;
        if (w == LIT_WID_12B)
            r = 17'h01000;
        else if (w == LIT_WID_8B)
            r = 17'h00100;
        else if (w == LIT_WID_4B)
            r = 17'h00010;
        return r;
    endfunction

    // Field decode
    wire        ext_mode  = cmd[LIT_CMD_TMODE_BIT];
    wire [1:0]  dsel      = cmd[LIT_CMD_DSEL_LSB +: 2];
    wire [1:0]  wid       = cmd[LIT_CMD_WID_LSB +: 2];
    wire [1:0]  gain      = ctrl[LIT_CTRL_GAIN_LSB +: 2];
    wire        slow      = ~gain[1];
    wire [16:0] target    = lit_cycles(wid);
    wire        active    = (dsel != LIT_DSEL_NOP);
    wire        diffm     = (dsel == LIT_DSEL_DIFF);

    // Same divider in both modes keeps the rate mode-independent
    wire        tick      = osc_rise & (~slow | half_ph);

    // APB decode
    wire        acc       = psel_in & penable_in;
    // Only the ready edge writes, so a sync is not issued twice
    wire        wr        = acc & pwrite_in & pready_out;
    wire        hit_cmd   = (paddr_in == LIT_ADDR_CMD);
    wire        hit_ctrl  = (paddr_in == LIT_ADDR_CTRL);
    wire        hit_sync  = (paddr_in == LIT_ADDR_SYNC);
    wire        hit_stat  = (paddr_in == LIT_ADDR_STATUS);
    wire        hit_cnt   = (paddr_in == LIT_ADDR_COUNT);
    wire        mapped    = hit_cmd | hit_ctrl | hit_sync | hit_stat | hit_cnt;
    wire        sync_cmd  = wr & hit_sync & pwdata_in[LIT_SYNC_BIT];
    wire        cfg_wr    = wr & (hit_cmd | hit_ctrl);

    // Period ends
    wire        int_done  = ~ext_mode & (state != LIT_ST_IDLE) & tick
                            & (cnt + 17'h00001 == target);
    wire        ext_step  = ext_mode & active & sync_cmd;
    wire        ext_done  = ext_step & (state != LIT_ST_IDLE);
    wire        period_end = int_done | ext_done;

    // Next state
    lit_state_t next_state;
    always_comb
    begin
        next_state = state;
        if (!active || cfg_wr)
            next_state = LIT_ST_IDLE;
        else if (!ext_mode)
        begin
            if (state == LIT_ST_IDLE)
                next_state = LIT_ST_RUN1;
            else if (int_done && diffm)
                next_state = (state == LIT_ST_RUN1) ? LIT_ST_RUN2
                                                    : LIT_ST_RUN1;
        end
        else if (ext_step)
        begin
            case (state)
                LIT_ST_IDLE: next_state = LIT_ST_RUN1;
                LIT_ST_RUN1: next_state = diffm ? LIT_ST_RUN2 : LIT_ST_RUN1;
                LIT_ST_RUN2: next_state = LIT_ST_RUN1;
                default:     next_state = LIT_ST_IDLE;
            endcase
        end
    end

    wire restart = (next_state != LIT_ST_IDLE)
                   & ((state == LIT_ST_IDLE) | period_end);

    // Saturating counter; host spacing keeps it in range
    wire [16:0] next_cnt = restart ? 17'h00000
                         : (tick && state != LIT_ST_IDLE
                            && cnt != LIT_CNT_MAX) ? cnt + 17'h00001
                         : cnt;

    // Read mux
    always_comb
    begin
        next_prdata = 32'h00000000;
        if (hit_cmd)
            next_prdata = {24'h000000, cmd};
        else if (hit_ctrl)
            next_prdata = {24'h000000, ctrl};
        else if (hit_stat)
            next_prdata = {29'h00000000, last_diode2, state};
        else if (hit_cnt)
            next_prdata = ext_mode ? {15'h0000, last_cnt}
                                   : {15'h0000, target};
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cmd  <= LIT_CMD_RST;
            ctrl <= LIT_CTRL_RST;
        end
        else
        begin
            if (wr && hit_cmd)
                cmd <= pwdata_in[7:0];
            if (wr && hit_ctrl)
                ctrl <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            half_ph <= 1'b0;
        else if (osc_rise)
            half_ph <= ~half_ph;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state <= LIT_ST_IDLE;
            cnt   <= 17'h00000;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            last_cnt    <= 17'h00000;
            last_diode2 <= 1'b0;
        end
        else if (period_end)
        begin
            // External count covers the whole host-timed period
            last_cnt    <= ext_mode ? next_cnt_hold(cnt, tick)
                                    : target;
            last_diode2 <= (state == LIT_ST_RUN2);
        end
    end

    function automatic logic [16:0] next_cnt_hold(input logic [16:0] c,
                                                  input logic        t);
        logic [16:0] r;
        r = c;
        if (t && c != LIT_CNT_MAX)
            r = c + 17'h00001;
        return r;
    endfunction

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            prdata_out     <= 32'h00000000;
            pready_out     <= 1'b0;
            pslverr_out    <= 1'b0;
            integrate_out  <= 1'b0;
            diode2_sel_out <= 1'b0;
            period_end_out <= 1'b0;
            osc_tick_out   <= 1'b0;
        end
        else
        begin
            // One wait state: ready in the second access cycle
            pready_out     <= psel_in & penable_in & ~pready_out;
            pslverr_out    <= psel_in & penable_in & ~pready_out & ~mapped;
            prdata_out     <= next_prdata;
            integrate_out  <= (next_state != LIT_ST_IDLE);
            diode2_sel_out <= (next_state == LIT_ST_RUN2)
                              | (dsel == LIT_DSEL_D2);
            period_end_out <= period_end;
            osc_tick_out   <= tick;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/lit_osc_model.sv
// Conversion oscillator model for the light integration timing bench.
// Assumes the bench asks for bursts; the pin rests low between them.
`timescale 1ns/1ps
`default_nettype none
module lit_osc_model
(
    // Pin
    output var logic osc_out
);
    initial osc_out = 1'b0;

    // Same 64 ns period in either timing mode; 3 ns skew keeps edges off clk
    task automatic pulses(input int n);
        #3;
        repeat (n)
        begin
            #32 osc_out = 1'b1;
            #32 osc_out = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ===== testbench/lit_chk.sv
// Port checker for the light integration timing block.
// Sees only the top ports; bound after the module.
`timescale 1ns/1ps
`default_nettype none
module lit_chk
    import lit_pkg::*;
(
    // System and bus
    input wire logic        clk_sys_in,
    input wire logic        nrst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // Converter side
    input wire logic        osc_in,
    input wire logic        integrate_out,
    input wire logic        diode2_sel_out,
    input wire logic        period_end_out,
    input wire logic        osc_tick_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    AST_RDY_LATE:
        assert property (psel_in && penable_in && !$past(penable_in)
            |=> pready_out) else $error("pready late");
    AST_RDY_ONE:
        assert property (pready_out |=> !pready_out)
            else $error("pready too long");
    AST_RDY_IDLE:
        assert property (!(psel_in && penable_in) |=> !pready_out)
            else $error("pready without access");
    AST_ERR_MAP:
        assert property (pready_out |-> pslverr_out ==
            (paddr_in > LIT_ADDR_COUNT || paddr_in[1:0] != 2'h0))
            else $error("pslverr wrong");
    AST_ERR_ZERO:
        assert property (pready_out && pslverr_out |-> prdata_out == 32'h0)
            else $error("refused read not zero");
    AST_END_ONE:
        assert property (period_end_out |=> !period_end_out)
            else $error("end pulse too long");
    AST_TICK_GAP:
        assert property (osc_tick_out |=> !osc_tick_out [*3])
            else $error("ticks too close");
    AST_END_INT:
        assert property (period_end_out |-> $past(integrate_out))
            else $error("end without integration");

    cover property (pready_out && pslverr_out);
    cover property (period_end_out && integrate_out);
    cover property ($rose(diode2_sel_out));
endmodule

bind lit_timing lit_chk lit_chk_i (.clk_sys_in, .nrst_in, .psel_in,
    .penable_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out,
    .osc_in, .integrate_out, .diode2_sel_out, .period_end_out,
    .osc_tick_out);
`default_nettype wire

// ===== testbench/tb_top.sv
// Bench for the light integration timing block, driven over APB.
// Assumes the oscillator model drives the pin and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lit_pkg::*;
;
    logic        clk_sys_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out, rd;
    logic        pready_out, pslverr_out, osc_in, integrate_out, err;
    logic        diode2_sel_out, period_end_out, osc_tick_out;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc, tk;

    always #4 clk_sys_in = ~clk_sys_in;

    lit_timing lit_timing_i (.clk_sys_in, .nrst_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .osc_in, .integrate_out, .diode2_sel_out,
        .period_end_out, .osc_tick_out);
    lit_osc_model lit_osc_model_i (.osc_out(osc_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Idle cycle after each transfer so no signal is set twice at one edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k = 0;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        @(posedge clk_sys_in);
        while (pready_out !== 1'b1 && k < 100)
        begin
            @(posedge clk_sys_in);
            k++;
        end
        if (k >= 100)
            n_errors++;
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Cycles and ticks from one end pulse to the next
    task automatic period();
        cyc = 0;
        tk = 0;
        while (period_end_out !== 1'b1 && tk < 5000)
        begin
            @(posedge clk_sys_in);
            tk++;
        end
        tk = 0;
        do
        begin
            @(posedge clk_sys_in);
            cyc++;
            tk += int'(osc_tick_out === 1'b1);
        end
        while (period_end_out !== 1'b1 && cyc < 5000);
    endtask

    function automatic logic [31:0] ecmd(input logic [1:0] ds);
        return (32'h1 << LIT_CMD_TMODE_BIT) | (32'(ds) << LIT_CMD_DSEL_LSB);
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #300000;
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (10) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(posedge clk_sys_in);
        rdc(LIT_ADDR_CMD, {24'h0, LIT_CMD_RST});
        rdc(LIT_ADDR_CTRL, {24'h0, LIT_CTRL_RST});
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset_regs done");
        fork
            lit_osc_model_i.pulses(1300);
            for (int g = 0; g < 4; g++)
            begin
                wr(LIT_ADDR_CTRL, 32'(g) << LIT_CTRL_GAIN_LSB);
                wr(LIT_ADDR_CMD, {30'h0, LIT_WID_4B});
                period();
                chk(tk, 32'd16);
                chk(cyc, g < 2 ? 32'd256 : 32'd128);
            end
        join
        @(posedge clk_sys_in);
        for (int w = 0; w < 4; w++)
        begin
            wr(LIT_ADDR_CMD, 32'(w));
            rdc(LIT_ADDR_COUNT, 32'h1 << (16 - 4 * w));
        end
        $display("test internal done");
        for (int g = 0; g < 4; g += 2)
        begin
            wr(LIT_ADDR_CTRL, 32'(g) << LIT_CTRL_GAIN_LSB);
            wr(LIT_ADDR_CMD, ecmd(LIT_DSEL_D1));
            chk({31'h0, integrate_out}, 32'h0);
            for (int b = 40; b > 0; b -= 30)
            begin
                wr(LIT_ADDR_SYNC, 32'h1);
                chk({31'h0, integrate_out}, 32'h1);
                lit_osc_model_i.pulses(b);
                repeat (4) @(posedge clk_sys_in);
            end
            wr(LIT_ADDR_SYNC, 32'h1);
            rdc(LIT_ADDR_COUNT, g < 2 ? 32'd5 : 32'd10);
        end
        $display("test external done");
        wr(LIT_ADDR_CMD, ecmd(LIT_DSEL_DIFF));
        for (int s = 0; s < 4; s++)
        begin
            wr(LIT_ADDR_SYNC, 32'h1);
            chk({31'h0, diode2_sel_out}, 32'(s % 2));
        end
        rdc(LIT_ADDR_STATUS, 32'h2);
        wr(LIT_ADDR_CMD, ecmd(LIT_DSEL_D2));
        wr(LIT_ADDR_SYNC, 32'h1);
        chk({31'h0, diode2_sel_out}, 32'h1);
        wr(LIT_ADDR_CMD, ecmd(LIT_DSEL_NOP));
        wr(LIT_ADDR_SYNC, 32'h1);
        chk({31'h0, integrate_out}, 32'h0);
        $display("test diode_modes done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
